// [logic/cpms_pkg.sv]
// constants and carriers for the configuration pin mode select block
// assumes one core clock domain and a synchronous active-high reset
package cpms_pkg;

    // synchroniser lane count and lane positions
    localparam int CPMS_SYNC_W = 6;
    localparam int CPMS_LN_SEL = 0;
    localparam int CPMS_LN_LAT = 1;
    localparam int CPMS_LN_BUS_WIDTH_SELECT = 2;
    localparam int CPMS_LN_CLOCK_MODE_SELECT = 3;
    localparam int CPMS_LN_PDN = 4;
    localparam int CPMS_LN_RXDET = 5;

    // synchroniser reset matches the reset configuration (latch rising, 24-bit,
    // powered down, no receiver), so release of srst shows no false strap change
    localparam logic [5:0] CPMS_SYNC_RST = 6'h06;

    // serial-side register defaults; power-down register low means powered down
    localparam logic CPMS_PD_N_REG_RST = 1'h0;
    localparam logic CPMS_SENSE_REG_RST = 1'h0;

    // pin-strap reset values of the configuration outputs
    localparam logic CPMS_LATCH_RISE_RST = 1'h1;
    localparam logic CPMS_BUS24_RST = 1'h1;

    // software write into the serial-side registers
    typedef struct packed {
        logic sense_level;
        logic power_down_n;
    } cpms_swreg_s;

    // configuration handed to the datapath
    typedef struct packed {
        logic serial_en;
        logic latch_rising;
        logic bus_24bit;
        logic dual_edge;
        logic clock_mode;
        logic powered_down;
        logic hotplug_level;
    } cpms_cfg_s;

endpackage

// [logic/cpms_sync.sv]
// two-flop synchroniser for a bundle of pin levels
// assumes levels are slow next to core_clk; each lane is caught on its own
`timescale 1ns/1ps
`default_nettype none
module cpms_sync (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // levels
    input wire logic [cpms_pkg::CPMS_SYNC_W-1:0] async_in,
    output logic [cpms_pkg::CPMS_SYNC_W-1:0] sync_out
);
    import cpms_pkg::*;

    logic [CPMS_SYNC_W-1:0] meta_r;
    logic [CPMS_SYNC_W-1:0] sync_r;

    // first stage feeds only the second stage
    always_ff @(posedge core_clk) begin
        if (srst) begin
            meta_r <= CPMS_SYNC_RST;
            sync_r <= CPMS_SYNC_RST;
        end else begin
            meta_r <= async_in;
            sync_r <= meta_r;
        end
    end

    assign sync_out = sync_r;

endmodule
`default_nettype wire

// [logic/cpms_top.sv]
// configuration pin mode select: gives the shared strap pins their meaning
// assumes pins are asynchronous to core_clk and the serial engine is outside
`timescale 1ns/1ps
`default_nettype none
module cpms_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic srst,
    // configuration pins
    input wire logic serial_config_select_pin,
    input wire logic latch_polarity_hotplug_pin,
    input wire logic bus_width_select,
    input wire logic clock_mode_select,
    input wire logic power_down_n,
    // receiver detect comparator result
    input wire logic rx_detect,
    // register writes from the serial engine
    input wire logic sw_wr,
    input wire cpms_pkg::cpms_swreg_s sw_wr_data,
    // serial engine reset, active low
    output logic serial_sm_rst_n,
    // configuration to the datapath
    output var cpms_pkg::cpms_cfg_s cfg,
    // receiver-sense open-drain pin
    output logic receiver_sense_out_o,
    output logic receiver_sense_out_oe
);
    import cpms_pkg::*;

    logic [CPMS_SYNC_W-1:0] pins_raw;
    logic [CPMS_SYNC_W-1:0] pins_s;
    logic sel_s;
    logic lat_s;
    logic bus_width_select_s;
    logic clock_mode_select_s;
    logic pdn_s;
    logic rxdet_s;
    logic pd_n_reg_r;
    logic sense_reg_r;
    logic sense_oe_r;
    logic sense_oe_nxt;
    logic wr_ok;
    cpms_cfg_s cfg_r;
    cpms_cfg_s cfg_nxt;

    assign pins_raw[CPMS_LN_SEL] = serial_config_select_pin;
    assign pins_raw[CPMS_LN_LAT] = latch_polarity_hotplug_pin;
    assign pins_raw[CPMS_LN_BUS_WIDTH_SELECT] = bus_width_select;
    assign pins_raw[CPMS_LN_CLOCK_MODE_SELECT] = clock_mode_select;
    assign pins_raw[CPMS_LN_PDN] = power_down_n;
    assign pins_raw[CPMS_LN_RXDET] = rx_detect;

    cpms_sync u_sync (
        .core_clk(core_clk),
        .srst(srst),
        .async_in(pins_raw),
        .sync_out(pins_s)
    );

    assign sel_s = pins_s[CPMS_LN_SEL];
    assign lat_s = pins_s[CPMS_LN_LAT];
    assign bus_width_select_s = pins_s[CPMS_LN_BUS_WIDTH_SELECT];
    assign clock_mode_select_s = pins_s[CPMS_LN_CLOCK_MODE_SELECT];
    assign pdn_s = pins_s[CPMS_LN_PDN];
    assign rxdet_s = pins_s[CPMS_LN_RXDET];

    // writes only once the enable has settled, so a write never races the reset
    assign wr_ok = sw_wr && cfg_r.serial_en && sel_s;

    // raw pin is the asynchronous reset; the registers take constants only
    always_ff @(posedge core_clk or negedge serial_config_select_pin) begin
        if (!serial_config_select_pin) begin
            pd_n_reg_r <= CPMS_PD_N_REG_RST;
            sense_reg_r <= CPMS_SENSE_REG_RST;
        end else if (srst) begin
            pd_n_reg_r <= CPMS_PD_N_REG_RST;
            sense_reg_r <= CPMS_SENSE_REG_RST;
        end else if (wr_ok) begin
            pd_n_reg_r <= sw_wr_data.power_down_n;
            sense_reg_r <= sw_wr_data.sense_level;
        end
    end

    // serial engine held in reset while the pin is low or the core is reset
    assign serial_sm_rst_n = serial_config_select_pin && !srst;

    // next configuration
    always_comb begin
        cfg_nxt = cfg_r;
        cfg_nxt.serial_en = sel_s;
        if (sel_s) begin
            cfg_nxt.hotplug_level = lat_s;
            cfg_nxt.powered_down = !pd_n_reg_r;
        end else begin
            cfg_nxt.hotplug_level = 1'h0;
            // edge choice ignores clock mode on purpose
            cfg_nxt.latch_rising = lat_s;
            cfg_nxt.bus_24bit = bus_width_select_s;
            cfg_nxt.dual_edge = !bus_width_select_s;
            cfg_nxt.clock_mode = clock_mode_select_s;
            cfg_nxt.powered_down = !pdn_s;
        end
    end

    // sense pulls low in strap mode when no receiver seen, in serial mode when software asks for low
    assign sense_oe_nxt = sel_s ? !sense_reg_r : !rxdet_s;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            cfg_r.serial_en <= 1'h0;
            cfg_r.latch_rising <= CPMS_LATCH_RISE_RST;
            cfg_r.bus_24bit <= CPMS_BUS24_RST;
            cfg_r.dual_edge <= !CPMS_BUS24_RST;
            cfg_r.clock_mode <= 1'h0;
            cfg_r.powered_down <= 1'h1;
            cfg_r.hotplug_level <= 1'h0;
            sense_oe_r <= 1'h1;
        end else begin
            cfg_r <= cfg_nxt;
            sense_oe_r <= sense_oe_nxt;
        end
    end

    assign cfg = cfg_r;
    // never drives high; the board pull-up makes the high level
    assign receiver_sense_out_o = 1'h0;
    assign receiver_sense_out_oe = sense_oe_r;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (srst);

    AST_EDGE_STRAP: assert property (
        (!sel_s) |=> (cfg_r.latch_rising == $past(lat_s)))
        else $error("latch edge does not follow the strap");

    AST_EDGE_CLKMODE: assert property (
        (!sel_s && $stable(sel_s) && $stable(lat_s) && $changed(clock_mode_select_s))
            |=> $stable(cfg_r.latch_rising))
        else $error("clock mode disturbed the latch edge");

    AST_HOTPLUG: assert property (
        (sel_s && cfg_r.serial_en) |=>
            (cfg_r.hotplug_level == $past(lat_s)) && $stable(cfg_r.latch_rising))
        else $error("hot-plug monitor wrong in serial mode");

    AST_SERIAL_EN: assert property (
        (sel_s ##1 sel_s) |-> cfg_r.serial_en)
        else $error("serial interface not enabled");

    AST_STRAP_CFG: assert property (
        (!sel_s) |=> (!cfg_r.serial_en && cfg_r.clock_mode == $past(clock_mode_select_s)
            && cfg_r.powered_down == !$past(pdn_s)))
        else $error("strap configuration not applied");

    AST_ASYNC_RST: assert property (
        (!serial_config_select_pin) |-> (!serial_sm_rst_n && pd_n_reg_r == CPMS_PD_N_REG_RST
            && sense_reg_r == CPMS_SENSE_REG_RST))
        else $error("serial side not held in reset");

    AST_PULSE_DEFAULTS: assert property (
        $rose(sel_s) |-> (pd_n_reg_r == CPMS_PD_N_REG_RST && sense_reg_r == CPMS_SENSE_REG_RST))
        else $error("registers not back at defaults after select pulse");

    AST_OPEN_DRAIN: assert property (
        receiver_sense_out_oe |-> (receiver_sense_out_o == 1'h0))
        else $error("sense output driven high");

    AST_SENSE_DETECT: assert property (
        (!sel_s) |=> (receiver_sense_out_oe == !$past(rxdet_s)))
        else $error("sense output does not follow receiver detect");

    AST_SENSE_SW: assert property (
        (wr_ok ##1 (sel_s && serial_config_select_pin))
            |=> (receiver_sense_out_oe == !$past(sw_wr_data.sense_level, 2)))
        else $error("sense output ignores the software level");

    AST_PD_DEFAULT: assert property (
        $rose(cfg_r.serial_en) |-> cfg_r.powered_down)
        else $error("serial mode did not start powered down");

    AST_BUS_WIDTH: assert property (
        (!sel_s) |=> (cfg_r.bus_24bit == $past(bus_width_select_s) && cfg_r.dual_edge == !$past(bus_width_select_s)))
        else $error("bus width strap decoded wrong");

    AST_SYNC_PATH: assert property (
        (!sel_s && $changed(bus_width_select)) |=> $stable(cfg_r.bus_24bit))
        else $error("raw strap reached configuration without synchroniser");

    AST_SM_RST_PIN: assert property (
        serial_config_select_pin |-> serial_sm_rst_n)
        else $error("serial engine held in reset with the select pin high");

    AST_HOTPLUG_STRAP: assert property (
        (!sel_s) |=> (cfg_r.hotplug_level == 1'h0))
        else $error("hot-plug level seen in strap mode");

    AST_STRAP_HELD: assert property (
        sel_s |=> ($stable(cfg_r.bus_24bit) && $stable(cfg_r.clock_mode)))
        else $error("strap fields moved in serial mode");

    AST_PD_SW: assert property (
        (wr_ok ##1 (sel_s && serial_config_select_pin))
            |=> (cfg_r.powered_down == !$past(sw_wr_data.power_down_n, 2)))
        else $error("power-down register write not applied");

    COV_ENTER_SERIAL: cover property ($rose(cfg_r.serial_en));
    COV_LEAVE_SERIAL: cover property ($fell(cfg_r.serial_en));
    COV_SW_WRITE: cover property (wr_ok ##1 sel_s ##1 !receiver_sense_out_oe);
    COV_HOTPLUG: cover property ($rose(cfg_r.hotplug_level));
    COV_RX_FOUND: cover property (!sel_s ##1 $fell(receiver_sense_out_oe));

endmodule
`default_nettype wire

// [dv/cpms_far_model.sv]
// far side of the pins: board pull-up on the sense line and the receiver
// assumes the receiver is dc-coupled, so its presence is a plain level
`timescale 1ns/1ps
`default_nettype none
module cpms_far_model (
    // open-drain sense pin from the block
    input wire logic sense_o,
    input wire logic sense_oe,
    output logic sense_wire,
    // receiver on the differential outputs
    input wire logic rx_powered,
    output logic rx_detect
);
    // pull-up gives the high level whenever the block lets go
    assign sense_wire = sense_oe ? sense_o : 1'b1;
    assign rx_detect = rx_powered;
endmodule
`default_nettype wire

// [dv/tb_config_pin_mode_select.sv]
// self-checking bench for the configuration pin mode select block
// assumes pins are driven 2 ns after the rising edge and settle in 5 cycles
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, exp, got) begin cmp_count++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("FAIL %s expected %0h seen %0h", nm, exp, got); end end
module tb_config_pin_mode_select;
    import cpms_pkg::*;
    logic core_clk = 1'b0;
    logic srst = 1'b1;
    logic sel = 1'b0;
    logic lat = 1'b1;
    logic bw = 1'b1;
    logic cm = 1'b0;
    logic pwr_n = 1'b0;
    logic rx_pw = 1'b0;
    logic sw_wr = 1'b0;
    cpms_swreg_s sw_wr_data = 2'h0;
    wire logic rx_detect;
    wire logic sense_wire;
    wire logic sm_rst_n;
    wire logic sense_o;
    wire logic sense_oe;
    cpms_cfg_s cfg;
    int n_mismatch = 0;
    int cmp_count = 0;
    int cycles = 0;

    always #25 core_clk = ~core_clk;

    cpms_top dut_u (
        .core_clk(core_clk), .srst(srst), .serial_config_select_pin(sel),
        .latch_polarity_hotplug_pin(lat), .bus_width_select(bw), .clock_mode_select(cm),
        .power_down_n(pwr_n), .rx_detect(rx_detect), .sw_wr(sw_wr), .sw_wr_data(sw_wr_data),
        .serial_sm_rst_n(sm_rst_n), .cfg(cfg), .receiver_sense_out_o(sense_o),
        .receiver_sense_out_oe(sense_oe)
    );
    cpms_far_model far_u (
        .sense_o(sense_o), .sense_oe(sense_oe), .sense_wire(sense_wire),
        .rx_powered(rx_pw), .rx_detect(rx_detect)
    );

    task automatic step(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask

    task automatic tally_and_finish;
        $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
        if (n_mismatch == 0 && cmp_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask

    // whole run is well under 200 cycles
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            n_mismatch++;
            $display("FAIL timeout expected 0 seen %0d", cycles);
            tally_and_finish();
        end
    end

    initial begin
        step(15);
        `CHK("reset cfg", 7'h32, cfg)
        `CHK("reset sm_rst_n", 1'b0, sm_rst_n)
        `CHK("reset sense", 1'b0, sense_wire)
        step(1);
        srst = 1'b0;
        $display("test reset done");
        // strap mode; a software write here must be dropped
        bw = 1'b0;
        lat = 1'b0;
        cm = 1'b1;
        pwr_n = 1'b1;
        rx_pw = 1'b1;
        sw_wr = 1'b1;
        step(1);
        sw_wr = 1'b0;
        step(1);
        `CHK("bus_24bit early", 1'b1, cfg.bus_24bit)
        step(4);
        `CHK("bus_24bit", 1'b0, cfg.bus_24bit)
        `CHK("dual_edge", 1'b1, cfg.dual_edge)
        `CHK("latch_rising", 1'b0, cfg.latch_rising)
        `CHK("clock_mode", 1'b1, cfg.clock_mode)
        `CHK("powered_down", 1'b0, cfg.powered_down)
        `CHK("hotplug strap", 1'b0, cfg.hotplug_level)
        `CHK("sense found", 1'b1, sense_wire)
        `CHK("sense_o", 1'b0, sense_o)
        bw = 1'b1;
        lat = 1'b1;
        rx_pw = 1'b0;
        step(5);
        `CHK("bus_24bit hi", 1'b1, cfg.bus_24bit)
        `CHK("dual_edge lo", 1'b0, cfg.dual_edge)
        `CHK("latch_rising hi", 1'b1, cfg.latch_rising)
        `CHK("sense none", 1'b0, sense_wire)
        $display("test strap done");
        // serial mode; strap-only inputs stop mattering
        sel = 1'b1;
        rx_pw = 1'b1;
        #1;
        `CHK("sm_rst_n up", 1'b1, sm_rst_n)
        step(5);
        `CHK("serial_en", 1'b1, cfg.serial_en)
        `CHK("pd default", 1'b1, cfg.powered_down)
        `CHK("hotplug hi", 1'b1, cfg.hotplug_level)
        `CHK("sense sw", 1'b0, sense_wire)
        lat = 1'b0;
        step(5);
        `CHK("hotplug lo", 1'b0, cfg.hotplug_level)
        `CHK("latch held", 1'b1, cfg.latch_rising)
        sw_wr = 1'b1;
        sw_wr_data = 2'h3;
        step(1);
        sw_wr = 1'b0;
        step(2);
        `CHK("pd written", 1'b0, cfg.powered_down)
        `CHK("sense written", 1'b1, sense_wire)
        $display("test serial done");
        // short low pulse: no clock edge needed for the engine reset
        sel = 1'b0;
        #1;
        `CHK("sm_rst_n async", 1'b0, sm_rst_n)
        step(1);
        sel = 1'b1;
        step(2);
        `CHK("serial_en dropped", 1'b0, cfg.serial_en)
        step(3);
        `CHK("serial_en back", 1'b1, cfg.serial_en)
        `CHK("pd restored", 1'b1, cfg.powered_down)
        `CHK("sense restored", 1'b0, sense_wire)
        $display("test pulse done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
